// >>> rtl/meas_trig_map.svh
// Offsets, field positions, reset values and timing counts of the trigger controller.
// Assumes a 10 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef MEAS_TRIG_MAP_SVH
`define MEAS_TRIG_MAP_SVH
// =====================================================================
// Register offsets.
`define OFS_CTRL        4'h0
`define OFS_RATE        4'h4
`define OFS_CMD         4'h8
`define OFS_STAT        4'hc
// =====================================================================
// Control field positions.
`define CTRL_SYNC_LSB   0
`define CTRL_SRC_LSB    2
`define CTRL_EDGE_BIT   4
`define CTRL_POL_BIT    5
`define CTRL_OUTG_BIT   6
`define CTRL_CNT_LSB    8
`define CTRL_RESET      32'h0000_0000
// =====================================================================
// Rates and timing.
`define CLK_HZ          10000000
`define RATE_DEF_HZ     4000
`define RATE_MIN_HZ     250
`define RATE_MAX_HZ     10000
`define RATE_DEF_DIV    16'h09c4
`define RATE_MIN_DIV    16'h03e8
`define RATE_MAX_DIV    16'h9c40
`define TRIG_MIN_US     50
`define TRIG_MIN_CYC    ((`TRIG_MIN_US * `CLK_HZ + 999999) / 1000000)
`define PIPE_CYCLES     4
`define CNT_MAX         14'h3fff
`endif

// >>> rtl/meas_trig_pkg.sv
// Types shared by the trigger controller.
// Assumes nothing of its surroundings.
package meas_trig_pkg;
  typedef enum logic [1:0] {
    SYNC_OFF   = 2'b00,
    SYNC_MAST  = 2'b01,
    SYNC_SLAVE = 2'b11,
    SYNC_MFI   = 2'b10
  } sync_mode_e;
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_MFI  = 2'b01,
    SRC_SYNC = 2'b11,
    SRC_SW   = 2'b10
  } trig_src_e;
  typedef enum logic [1:0] {
    ST_FREE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_BURST = 2'b11,
    ST_HOLD  = 2'b10
  } gate_st_e;
endpackage

// >>> rtl/edge_filter.sv
// Minimum-width filter for a trigger pin; accepts a level once stable for a time.
// Assumes the pin is synchronous to aclk.
`timescale 1ns/10ps
`default_nettype none
module edge_filter #(
  parameter int W = 10
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         din,
  input  wire logic [W-1:0] min_cyc,
  output logic              dout
);
  logic [W-1:0] cnt_r;  // Cycles the input has differed from the output.
  // ===================================================================
  // Stable-time counter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      dout  <= 1'b0;
    end else if (ce) begin
      if (din == dout) begin
        cnt_r <= '0;
      end else if (cnt_r + 1'b1 >= min_cyc) begin
        dout  <= din;  // Held long enough: accept the new level.
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/meas_trig_ctrl.sv
// Measurement cycle, trigger gating and sync-link control of a displacement sensor.
// Assumes synchronous pins, a 10 MHz aclk and an AXI4-Lite master.
// Functional notes
// - Master drives symmetric pulses; slave follows them.
// - Sync pair direction follows synchronization mode.
// - Two masters detected: laser off, no measuring.
// - Measuring rate free value, 250 Hz-10 kHz typical.
// - One exposure per cycle, 10 kHz maximum.
// - Measuring rate resets to 4 kHz.
// - Output follows trigger four plus one cycles.
// - Trigger gates analog and switching outputs.
// - Default: no trigger, continuous output.
// - Source: input, sync, software or inactive.
// - Acquisition and output gating share timing.
// - Polarity high/rising or low/falling.
// - Level mode runs while level present.
// - Edge starts burst of count or infinite.
// - Analog output holds last burst value.
// - Software trigger starts count or continuous.
// - Stop command restores continuous output; here only during a software-triggered burst.
// - Acquisition trigger discards pre-trigger values.
// - Output trigger computes continuously, gates output.
`include "meas_trig_map.svh"
`timescale 1ns/10ps
`default_nettype none
module meas_trig_ctrl
  import meas_trig_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        mfi_in,
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             sync_oe_n,
  output logic             laser_on,
  output logic             expose,
  output logic             acq_valid,
  output logic             out_valid
);
  // ===================================================================
  // Registers.
  logic [31:0] ctrl_r;        // Mode, source, edge, polarity, gating, count.
  logic [15:0] rate_div_r;    // Clocks per measuring cycle.
  logic        sw_go_r;       // One-cycle software trigger pulse.
  logic        sw_stop_r;     // One-cycle stop pulse.
  logic        conflict_r;    // Sticky two-master flag.
  logic        clr_conf_r;    // One-cycle request to clear the flag.
  logic        cfg_wr_r;      // One-cycle pulse after a control write.
  gate_st_e    st_r;          // Gate state.
  logic [13:0] left_r;        // Burst measurements left.
  logic [15:0] div_r;         // Cycle divider.
  logic        tick_r;        // One-cycle measuring cycle strobe.
  logic [`PIPE_CYCLES-1:0] gate_pipe_r;  // Delay of the gate to output.
  logic        trig_prev_r;   // Previous filtered trigger level.
  logic        sync_prev_r;   // Previous sync input level.
  logic        aw_ok_r, w_ok_r;
  logic [3:0]  aw_r;
  logic [31:0] w_r;
  sync_mode_e  mode;
  trig_src_e   src;
  logic        edge_mode, pol_low, outg, trig_raw, trig_f, trig_act, trig_edge;
  logic        gate_now, infinite;
  logic [13:0] count_cfg;
  assign mode      = sync_mode_e'(ctrl_r[`CTRL_SYNC_LSB +: 2]);
  assign src       = trig_src_e'(ctrl_r[`CTRL_SRC_LSB +: 2]);
  assign edge_mode = ctrl_r[`CTRL_EDGE_BIT];
  assign pol_low   = ctrl_r[`CTRL_POL_BIT];
  assign outg      = ctrl_r[`CTRL_OUTG_BIT];
  assign count_cfg = ctrl_r[`CTRL_CNT_LSB +: 14];
  assign infinite  = (count_cfg == 14'h0000);
  // Source select: the pin or the sync input, raw.
  assign trig_raw = (src == SRC_MFI) ? mfi_in : (src == SRC_SYNC) ? sync_in : 1'b0;
  // ===================================================================
  // Edge pulses shorter than the minimum width are ignored.
  edge_filter #(.W(10)) u_filt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .din     (trig_raw),
    .min_cyc (10'(`TRIG_MIN_CYC)),
    .dout    (trig_f)
  );
  assign trig_act  = trig_f ^ pol_low;
  assign trig_edge = trig_act & ~(trig_prev_r ^ pol_low);
  // ===================================================================
  // AXI4-Lite write path; address and data accepted in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      w_ok_r  <= 1'b0;
      aw_r    <= 4'h0;
      w_r     <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_r <= 1'b1;
        aw_r    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_r <= 1'b1;
        w_r    <= s_axi_wdata;
      end
      if (aw_ok_r && w_ok_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        aw_ok_r <= 1'b0;
        w_ok_r  <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'b00;
  assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok_r && !s_axi_bvalid;
  // Register update on a completed write; commands are single-cycle pulses.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= `CTRL_RESET;
      rate_div_r <= `RATE_DEF_DIV;
      sw_go_r    <= 1'b0;
      sw_stop_r  <= 1'b0;
      clr_conf_r <= 1'b0;
      cfg_wr_r   <= 1'b0;
    end else if (ce) begin
      sw_go_r    <= 1'b0;
      sw_stop_r  <= 1'b0;
      clr_conf_r <= 1'b0;
      cfg_wr_r   <= 1'b0;
      if (aw_ok_r && w_ok_r && !s_axi_bvalid && (&s_axi_wstrb | 1'b1)) begin
        cfg_wr_r <= (aw_r == `OFS_CTRL);  // A new setup re-arms the gate.
        case (aw_r)
          `OFS_CTRL: ctrl_r <= w_r & 32'h003f_ff7f;
          `OFS_RATE: begin
            // Free rate clamped to the exposure limit and slowest cycle.
            if (w_r[15:0] < `RATE_MIN_DIV) rate_div_r <= `RATE_MIN_DIV;
            else if (w_r[15:0] > `RATE_MAX_DIV) rate_div_r <= `RATE_MAX_DIV;
            else rate_div_r <= w_r[15:0];
          end
          `OFS_CMD: begin
            sw_go_r    <= w_r[0];
            sw_stop_r  <= w_r[1];
            clr_conf_r <= w_r[2];
          end
          default: ;
        endcase
      end
    end
  end
  // ===================================================================
  // AXI4-Lite read path; unmapped offsets read as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        case (s_axi_araddr)
          `OFS_CTRL: s_axi_rdata <= ctrl_r;
          `OFS_RATE: s_axi_rdata <= {16'h0000, rate_div_r};
          `OFS_STAT: s_axi_rdata <= {16'h0000, left_r, conflict_r, st_r == ST_BURST};
          default:   s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp   = 2'b00;
  // ===================================================================
  // Measuring cycle: free-running divider, or restarted by master pulses or trigger edges.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r       <= 16'h0000;
      tick_r      <= 1'b0;
      sync_prev_r <= 1'b0;
    end else if (ce) begin
      sync_prev_r <= sync_in;
      tick_r      <= 1'b0;
      if (mode == SYNC_SLAVE || mode == SYNC_MFI) begin
        // Slaves time their cycles on the rising edge of the sync signal.
        if ((mode == SYNC_SLAVE ? sync_in & ~sync_prev_r : trig_edge)) tick_r <= !conflict_r;
      end else if (div_r >= rate_div_r - 16'h0001) begin
        div_r  <= 16'h0000;
        tick_r <= !conflict_r;
      end else begin
        div_r <= div_r + 16'h0001;
      end
    end
  end
  // Master output: high for the first half of each cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_out  <= 1'b0;
      sync_oe_n <= 1'b1;
    end else if (ce) begin
      sync_oe_n <= !(mode == SYNC_MAST);
      sync_out  <= (mode == SYNC_MAST) && (div_r < {1'b0, rate_div_r[15:1]});
    end
  end
  // Two masters: the pair reads back a level other than the one driven.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conflict_r <= 1'b0;
      laser_on   <= 1'b1;
    end else if (ce) begin
      if (!sync_oe_n && (sync_in != sync_out)) conflict_r <= 1'b1;
      else if (clr_conf_r) conflict_r <= 1'b0;
      laser_on <= !conflict_r;
    end
  end
  // ===================================================================
  // Gate state machine; evaluated every enabled clock, burst counted down on measuring cycle strobes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r        <= ST_FREE;
      left_r      <= 14'h0000;
      trig_prev_r <= 1'b0;
    end else if (ce) begin
      trig_prev_r <= trig_f;
      case (st_r)
        ST_FREE: if (src == SRC_SW && sw_go_r) begin
          st_r   <= ST_BURST;
          left_r <= count_cfg;
        end
        ST_WAIT: begin
          if (src == SRC_NONE) st_r <= ST_FREE;
          else if ((src == SRC_SW) ? sw_go_r : (edge_mode ? trig_edge : trig_act)) begin
            st_r   <= ST_BURST;
            left_r <= count_cfg;
          end
        end
        ST_BURST: begin
          if (src == SRC_NONE || (src == SRC_SW && sw_stop_r)) st_r <= ST_FREE;
          else if (src != SRC_SW && !edge_mode && !trig_act) st_r <= ST_WAIT;
          else if ((src == SRC_SW || edge_mode) && tick_r && !infinite) begin
            if (left_r == 14'h0001) st_r <= ST_HOLD;
            left_r <= left_r - 14'h0001;
          end
        end
        ST_HOLD: st_r <= ST_WAIT;
        default: st_r <= ST_FREE;
      endcase
      // A control write restarts gating, so a new mode never inherits a burst.
      if (cfg_wr_r) st_r <= (src == SRC_NONE) ? ST_FREE : ST_WAIT;
    end
  end
  assign gate_now = (st_r == ST_FREE) || (st_r == ST_BURST);
  // Gate passes a four-cycle pipeline, same path for both gating kinds.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_pipe_r <= '1;
    end else if (ce && tick_r) begin
      gate_pipe_r <= {gate_pipe_r[`PIPE_CYCLES-2:0], gate_now};
    end
  end
  // Exposure each cycle; output strobe gated, acquisition strobe gated unless output gating is set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expose    <= 1'b0;
      acq_valid <= 1'b0;
      out_valid <= 1'b0;
    end else if (ce) begin
      expose    <= tick_r;
      acq_valid <= tick_r && (outg || gate_pipe_r[`PIPE_CYCLES-1]);
      out_valid <= tick_r && gate_pipe_r[`PIPE_CYCLES-1];
    end
  end
  // ===================================================================
  // Checks.
  property p_conflict_laser;
    @(posedge aclk) disable iff (!aresetn)
      (ce && conflict_r) |=> !laser_on;
  endproperty
  a_conflict_laser: assert property (p_conflict_laser) else $error("laser on during conflict");
  property p_no_tick_conflict;
    @(posedge aclk) disable iff (!aresetn)
      $past(conflict_r) && $past(ce) && conflict_r |-> !tick_r;
  endproperty
  a_no_tick_conflict: assert property (p_no_tick_conflict) else $error("tick in conflict");
  property p_dir;
    @(posedge aclk) disable iff (!aresetn)
      ce && mode == SYNC_SLAVE |=> sync_oe_n;
  endproperty
  a_dir: assert property (p_dir) else $error("slave drives sync");
  property p_out_gate;
    @(posedge aclk) disable iff (!aresetn)
      out_valid |-> $past(tick_r);
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("output without cycle");
  property p_acq_sup;
    @(posedge aclk) disable iff (!aresetn)
      out_valid |-> acq_valid;
  endproperty
  a_acq_sup: assert property (p_acq_sup) else $error("output without acquisition");
  property p_rate_min;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |-> rate_div_r >= `RATE_MIN_DIV && rate_div_r <= `RATE_MAX_DIV;
  endproperty
  a_rate_min: assert property (p_rate_min) else $error("rate out of range");
  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
      ce && st_r == ST_HOLD |=> st_r == ST_WAIT;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not followed by wait");
  property p_stop;
    @(posedge aclk) disable iff (!aresetn)
      ce && st_r == ST_BURST && src == SRC_SW && sw_stop_r |=> st_r == ST_FREE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  c_burst: cover property (@(posedge aclk) st_r == ST_WAIT ##1 st_r == ST_BURST);
  c_done:  cover property (@(posedge aclk) st_r == ST_HOLD);
  c_conf:  cover property (@(posedge aclk) conflict_r);
endmodule
`default_nettype wire

// >>> dv/trig_peer.sv
// Far-side model: trigger source on the multi-function input and a peer sensor on the sync pair.
// Assumes the bench commands trig_lvl and peer_master right after rising edges of aclk.
`timescale 1ns/10ps
`default_nettype none
module trig_peer (
  input  wire logic aclk,
  input  wire logic trig_lvl,
  input  wire logic peer_master,
  input  wire logic sync_out,
  input  wire logic sync_oe_n,
  output logic      mfi_in,
  output logic      sync_in
);
  logic        last_r = 1'b0;    // Last level seen on the sync pair.
  logic [11:0] pcnt_r = 12'h000; // Phase of the peer's own master pulses.

  // The trigger source holds every level longer than the filter; the shortest, 600 clocks, is under one cycle.
  assign mfi_in = trig_lvl;

  // A following peer echoes our pulses; a second master fights them.
  // A peer master alone drives its own pulses; an idle pair wanders.
  always_comb begin
    if (!sync_oe_n) begin
      sync_in = peer_master ? ~sync_out : sync_out;
    end else if (peer_master) begin
      sync_in = (pcnt_r < 12'd750);  // Symmetric pulses, 1500 clocks a cycle.
    end else begin
      sync_in = ~last_r;
    end
  end

  // Remember the pair level so that an undriven pair never shows a stale value.
  always @(posedge aclk) begin
    last_r <= sync_in;
    pcnt_r <= (pcnt_r == 12'd1499) ? 12'h000 : pcnt_r + 12'h001;
  end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the trigger controller: registers, rate, sync link and gating.
// Assumes the controller, its package, its map header and the far-side model are compiled.
`timescale 1ns/10ps
`default_nettype none
`include "meas_trig_map.svh"
module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig_lvl, peer_master;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata_q;
  wire         awready, wready, bvalid, arready, rvalid, mfi_in, sync_in;
  wire         sync_out, sync_oe_n, laser_on, expose, acq_valid, out_valid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          n_fail, n_tests, cyc, n_exp, n_out, n_acq, n_hi, t_prev, t_last, t_out, a, b, c0;

  // ==========================================================================
  // Design, far side and clock.
  meas_trig_ctrl dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mfi_in(mfi_in),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe_n(sync_oe_n), .laser_on(laser_on),
    .expose(expose), .acq_valid(acq_valid), .out_valid(out_valid));
  trig_peer peer (.aclk(aclk), .trig_lvl(trig_lvl), .peer_master(peer_master),
    .sync_out(sync_out), .sync_oe_n(sync_oe_n), .mfi_in(mfi_in), .sync_in(sync_in));

  // The 10 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Counts pulses and remembers when they came, in clock cycles.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (expose === 1'b1) begin
      n_exp  <= n_exp + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
    if (out_valid === 1'b1) begin
      n_out <= n_out + 1;
      t_out <= cyc;
    end
    if (acq_valid === 1'b1) n_acq <= n_acq + 1;
    if (sync_out === 1'b1) n_hi <= n_hi + 1;
  end

  // ==========================================================================
  // Bus, wait and compare tasks.
  task automatic wr(input logic [3:0] ad_i, input logic [31:0] d);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr  <= ad_i;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad_i);
    @(posedge aclk);
    araddr  <= ad_i;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rdata_q = rdata;
    rready  <= 1'b0;
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Waits for the given number of further exposures.
  task automatic wait_exp(input int k);
    int s;
    s = n_exp;
    while (n_exp < s + k) @(posedge aclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    chk({31'h0, sync_oe_n}, 32'h1);
    chk({31'h0, laser_on}, 32'h1);
    rd(`OFS_CTRL);
    chk(rdata_q, `CTRL_RESET);
    rd(`OFS_RATE);
    chk(rdata_q, {16'h0, `RATE_DEF_DIV});
    wait_exp(2);
    chk(t_last - t_prev, {16'h0, `RATE_DEF_DIV});
  endtask

  task automatic t_rate();
    wr(`OFS_RATE, 32'h0000_03e8);
    rd(`OFS_RATE);
    chk(rdata_q, 32'h0000_03e8);
    wait_exp(3);
    chk(t_last - t_prev, 32'h0000_03e8);
    b = n_out;
    wait_exp(4);
    chk(n_out - b, 32'h4);
  endtask

  task automatic t_master();
    wr(`OFS_CTRL, 32'h0000_0001);
    wait_exp(2);
    chk({31'h0, sync_oe_n}, 32'h0);
    b = n_hi;
    wait_exp(2);
    chk(n_hi - b, 32'd1000);
  endtask

  task automatic t_conflict();
    peer_master <= 1'b1;
    cyc_wait(3000);
    chk({31'h0, laser_on}, 32'h0);
    b = n_exp;
    cyc_wait(3000);
    chk(n_exp - b, 32'h0);
    peer_master <= 1'b0;
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_CMD, 32'h4);
    cyc_wait(10);
    chk({31'h0, laser_on}, 32'h1);
  endtask

  task automatic t_sw();
    wr(`OFS_CTRL, 32'h0000_0308);
    cyc_wait(6000);
    b = n_out;
    cyc_wait(3000);
    chk(n_out - b, 32'h0);
    wr(`OFS_CMD, 32'h1);
    cyc_wait(10000);
    chk(n_out - b, 32'h3);
    wr(`OFS_CTRL, 32'h003f_ff08);
    rd(`OFS_CTRL);
    chk(rdata_q, 32'h003f_ff08);
    wr(`OFS_CMD, 32'h1);
    cyc_wait(3000);
    wr(`OFS_CMD, 32'h2);
    cyc_wait(6000);
    rd(`OFS_STAT);
    chk({31'h0, rdata_q[0]}, 32'h0);
    b = n_out;
    wait_exp(4);
    chk(n_out - b, 32'h4);
  endtask

  // Level gating on the multi-function input, gating acquisition.
  task automatic t_level();
    wr(`OFS_CTRL, 32'h0000_0004);
    cyc_wait(6000);
    b = n_out;
    a = n_acq;
    trig_lvl <= 1'b1;
    c0 = cyc;
    while (n_out == b) @(posedge aclk);
    chk({31'h0, (t_out - c0 >= 4000) && (t_out - c0 <= 5600)}, 32'h1);
    cyc_wait(5000);
    trig_lvl <= 1'b0;
    cyc_wait(7000);
    chk({31'h0, (n_out - b >= 8) && (n_out - b <= 12)}, 32'h1);
    chk(n_acq - a, n_out - b);
    b = n_out;
    cyc_wait(3000);
    chk(n_out - b, 32'h0);
  endtask

  // Falling-edge burst of two, gating output only.
  task automatic t_edge();
    trig_lvl <= 1'b1;
    cyc_wait(2000);
    wr(`OFS_CTRL, 32'h0000_0274);
    cyc_wait(6000);
    b = n_out;
    a = n_acq;
    trig_lvl <= 1'b0;
    cyc_wait(600);
    trig_lvl <= 1'b1;
    cyc_wait(9000);
    chk(n_out - b, 32'h2);
    chk({31'h0, n_acq - a >= 9}, 32'h1);
  endtask

  // Slave timing taken from a peer master's pulses on the sync pair.
  task automatic t_slave();
    peer_master <= 1'b1;
    wr(`OFS_CTRL, 32'h0000_0003);
    wait_exp(3);
    chk(t_last - t_prev, 32'd1500);
    chk({31'h0, sync_oe_n}, 32'h1);
    chk({31'h0, laser_on}, 32'h1);
  endtask

  // ==========================================================================
  // Verdict, main sequence and watchdog.
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, trig_lvl, peer_master} = '0;
    {awaddr, araddr, wdata} = '0;
    {n_fail, n_tests, cyc, n_exp, n_out, n_acq, n_hi, t_prev, t_last, t_out} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rate();
    t_master();
    t_conflict();
    t_sw();
    t_level();
    t_edge();
    t_slave();
    close_out();
  end

  initial begin
    repeat (125000) @(posedge aclk);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
